// ---- dat_pkg.sv ----
// package: timing constants and command codes for the dram timing guard
package dat_pkg;
  localparam int unsigned CLK_PS         = 4000;
  localparam int unsigned MRD_PDA_NCK    = 16;
  localparam int unsigned MRD_PDA_NS     = 10;
  localparam int unsigned WLMRD_NCK      = 40;
  localparam int unsigned WLDQSEN_NCK    = 25;
  localparam int unsigned RFC1_NS        = 350;
  localparam int unsigned RFC2_NS        = 260;
  localparam int unsigned RFC4_NS        = 160;
  localparam int unsigned PAR_RSP_2933   = 78;
  localparam int unsigned PAR_RSP_3200   = 85;
  localparam int unsigned PL_NCK         = 6;
  localparam int unsigned MOD_NCK        = 24;
  localparam int unsigned DLLK_NCK       = 768;
  localparam int unsigned WR_NS          = 15;
  localparam int unsigned WR_CRC_DM_NS   = 19;
  localparam int unsigned WTR_NS         = 8;
  localparam int unsigned WTR_CRC_DM_NS  = 12;
  localparam int unsigned CNT_W          = 12;

  // rounds a nanosecond figure up to whole clock cycles, at least one
  function automatic int unsigned ns2ck(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned MRD_PDA_CK =
    (ns2ck(MRD_PDA_NS) > MRD_PDA_NCK) ? ns2ck(MRD_PDA_NS) : MRD_PDA_NCK;

  typedef enum logic [3:0] {
    DAT_CMD_DES, DAT_CMD_MRS, DAT_CMD_REF, DAT_CMD_ACT, DAT_CMD_RD,
    DAT_CMD_RDA, DAT_CMD_WR, DAT_CMD_WRA, DAT_CMD_PRE, DAT_CMD_ODT,
    DAT_CMD_WLV, DAT_CMD_SRX, DAT_CMD_PDE
  } dat_cmd_t;

  typedef enum logic [1:0] {
    DAT_RFC_1X, DAT_RFC_2X, DAT_RFC_4X
  } dat_rfc_t;
endpackage

// ---- dat_cnt_if.sv ----
// interface: load and status lines of one timing down-counter
`timescale 1ns/1ps
interface dat_cnt_if;
  logic                   load;
  logic [dat_pkg::CNT_W-1:0] value;
  logic                   busy;
  modport ctl (output load, output value, input busy);
  modport cnt (input load, input value, output busy);
endinterface

// ---- dat_down_cnt.sv ----
// module: one down-counter guarding a single timing constraint
`timescale 1ns/1ps
module dat_down_cnt
  import dat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  dat_cnt_if.cnt   port_i
);
  logic [CNT_W-1:0] cnt_q;

  // load restarts the wait; the count then runs down to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (port_i.load) begin
      cnt_q <= port_i.value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign port_i.busy = (cnt_q != '0);
endmodule

// ---- dat_guard.sv ----
// module: command timing guard for a ddr4 controller
`timescale 1ns/1ps
module dat_guard
  import dat_pkg::*;
#(
  parameter int unsigned DLLK_CYC = DLLK_NCK
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] req_cmd,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [1:0] rfc_mode,
  input  wire logic       pda_mode,
  input  wire logic       crc_en,
  input  wire logic       write_data_mask_en,
  input  wire logic       persist_par,
  input  wire logic       grade_3200,
  input  wire logic       alert_n_pin,
  output logic [3:0]      dram_cmd_q,
  output logic            dqs_oe_q,
  output logic            dqs_edge_ok_q,
  output logic            par_err_q,
  output logic            cmd_lost_q,
  output logic            rsp_late_q
);
  // ****************************************************
  // counters, one per constraint
  // ****************************************************
  localparam int NC = 7;
  localparam int C_MRD = 0, C_MOD = 1, C_RFC = 2, C_WLD = 3, C_WLM = 4;
  localparam int C_DLL = 5, C_WTR = 6;

  dat_cnt_if cif[NC] ();
  logic [CNT_W-1:0] ld_val [NC];
  logic [NC-1:0]    ld;
  logic [NC-1:0]    busy;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cnt
      assign cif[g].load  = ld[g];
      assign cif[g].value = ld_val[g];
      assign busy[g]      = cif[g].busy;
      dat_down_cnt u_cnt (
        .clk    (clk),
        .nrst   (nrst),
        .port_i (cif[g])
      );
    end
  endgenerate

  dat_cmd_t cmd;
  logic     take;
  logic     blocked;
  assign cmd  = dat_cmd_t'(req_cmd);
  assign take = req_valid && req_ready;

  function automatic logic [CNT_W-1:0] ck(input int unsigned n);
    return CNT_W'(n);
  endfunction

  // ****************************************************
  // refresh and write turnaround values
  // ****************************************************
  logic [CNT_W-1:0] rfc_ck;
  logic [CNT_W-1:0] wtr_ck;
  always_comb begin
    unique case (dat_rfc_t'(rfc_mode))
      DAT_RFC_2X: rfc_ck = ck(ns2ck(RFC2_NS));
      DAT_RFC_4X: rfc_ck = ck(ns2ck(RFC4_NS));
      default:    rfc_ck = ck(ns2ck(RFC1_NS));
    endcase
  end
  // the write turnaround also spans recovery, rounded up from ns
  always_comb begin
    if (crc_en && write_data_mask_en)
      wtr_ck = ck(ns2ck(WR_CRC_DM_NS) + ns2ck(WTR_CRC_DM_NS));
    else
      wtr_ck = ck(ns2ck(WR_NS) + ns2ck(WTR_NS));
  end

  // ****************************************************
  // issue check
  // ****************************************************
  logic rsp_busy;
  always_comb begin
    blocked = 1'b0;
    unique case (cmd)
      DAT_CMD_MRS: blocked = pda_mode && busy[C_MRD];
      DAT_CMD_ACT,
      DAT_CMD_REF: blocked = busy[C_RFC] || (pda_mode && busy[C_MOD]);
      DAT_CMD_RD,
      DAT_CMD_RDA,
      DAT_CMD_ODT: blocked = busy[C_DLL] || busy[C_WTR] ||
                             (pda_mode && busy[C_MOD]);
      DAT_CMD_DES: blocked = 1'b0;
      default:     blocked = pda_mode && busy[C_MOD];
    endcase
  end
  // persistent parity: only deselects pass while par_err_q flags a parity error
  assign req_ready = !blocked && !(par_err_q && persist_par &&
                                   cmd != DAT_CMD_DES);

  always_comb begin
    ld = '0;
    for (int i = 0; i < NC; i++) ld_val[i] = '0;
    ld_val[C_MRD] = ck(MRD_PDA_CK);
    ld_val[C_MOD] = ck(MOD_NCK);
    ld_val[C_RFC] = rfc_ck;
    ld_val[C_WLD] = ck(WLDQSEN_NCK);
    ld_val[C_WLM] = ck(WLMRD_NCK);
    ld_val[C_DLL] = ck(DLLK_CYC);
    ld_val[C_WTR] = wtr_ck;
    if (take) begin
      ld[C_MRD] = (cmd == DAT_CMD_MRS);
      ld[C_MOD] = (cmd == DAT_CMD_MRS);
      ld[C_RFC] = (cmd == DAT_CMD_REF);
      ld[C_WLD] = (cmd == DAT_CMD_WLV);
      ld[C_WLM] = (cmd == DAT_CMD_WLV);
      ld[C_DLL] = (cmd == DAT_CMD_SRX);
      ld[C_WTR] = (cmd == DAT_CMD_WR) || (cmd == DAT_CMD_WRA);
    end
  end

  // ****************************************************
  // command output and strobe gating
  // ****************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) dram_cmd_q <= 4'h0;
    else       dram_cmd_q <= take ? req_cmd : 4'h0;
  end

  logic wl_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                           wl_q <= 1'b0;
    else if (take && cmd == DAT_CMD_WLV) wl_q <= 1'b1;
    else if (take && cmd == DAT_CMD_MRS) wl_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dqs_oe_q      <= 1'b0;
      dqs_edge_ok_q <= 1'b0;
    end else begin
      dqs_oe_q      <= wl_q && !busy[C_WLD] && !ld[C_WLD];
      dqs_edge_ok_q <= wl_q && !busy[C_WLM] && !ld[C_WLM];
    end
  end

  // ****************************************************
  // alert handling
  // ****************************************************
  logic alert_s1_q;
  logic alert_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_s1_q <= 1'b1;
      alert_s2_q <= 1'b1;
    end else begin
      alert_s1_q <= alert_n_pin;
      alert_s2_q <= alert_s1_q;
    end
  end

  // a long low alert is parity; a short one is a write crc error
  logic [7:0] alert_len_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)            alert_len_q <= 8'h00;
    else if (alert_s2_q)  alert_len_q <= 8'h00;
    else if (alert_len_q != 8'hFF) alert_len_q <= alert_len_q + 8'h01;
  end

  // crc pulses end within 10 cycles, so 11 low cycles mark parity
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                    par_err_q <= 1'b0;
    else if (alert_len_q == 8'h0B) par_err_q <= 1'b1;
    else if (alert_s2_q)          par_err_q <= 1'b0;
  end

  // commands sent within parity latency of the error may be lost; the
  // alert lands up to parity latency plus 6 ns after the bad command,
  // then crosses two sync flops and the length counter before we look
  localparam int LOST_W = PL_NCK + 7;
  logic [LOST_W-1:0] recent_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) recent_q <= '0;
    else       recent_q <= {recent_q[LOST_W-2:0],
                            take && cmd != DAT_CMD_DES};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)                 cmd_lost_q <= 1'b0;
    else if (alert_len_q == 8'h01)
      cmd_lost_q <= |recent_q;
    else if (alert_s2_q)       cmd_lost_q <= 1'b0;
  end

  // with persistent parity on, reports if the deselect window passed with a non-deselect taken
  logic [7:0] rsp_lim;
  assign rsp_lim  = grade_3200 ? 8'(PAR_RSP_3200) : 8'(PAR_RSP_2933);
  assign rsp_busy = !alert_s2_q && (alert_len_q >= rsp_lim);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rsp_late_q <= 1'b0;
    else if (alert_s2_q) rsp_late_q <= 1'b0;
    else if (persist_par && rsp_busy && take && cmd != DAT_CMD_DES)
      rsp_late_q <= 1'b1;
  end
endmodule

// ---- dat_guard_asserts.sv ----
// checker: timing assertions on the ports of the command timing guard
`timescale 1ns/1ps
module dat_guard_asserts
  import dat_pkg::*;
#(
  parameter int unsigned DLLK_CYC = DLLK_NCK
)
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [1:0] rfc_mode,
  input wire logic       pda_mode,
  input wire logic       crc_en,
  input wire logic       write_data_mask_en,
  input wire logic       persist_par,
  input wire logic [3:0] dram_cmd_q,
  input wire logic       dqs_oe_q,
  input wire logic       dqs_edge_ok_q,
  input wire logic       par_err_q
);
  // cycles since the last issue of mrs, ref, wlv, srx and wr
  localparam logic [3:0] KEY [5] = '{4'h1, 4'h2, 4'hA, 4'hB, 4'h6};
  logic [11:0] age_q [5];
  logic [11:0] rfc_ck;
  logic [11:0] wtr_ck;
  logic        rd_i;
  always_ff @(posedge clk or negedge nrst) begin
    for (int i = 0; i < 5; i++) begin
      if (!nrst) age_q[i] <= 12'hFFF;
      else if (dram_cmd_q == KEY[i]) age_q[i] <= 12'h001;
      else if (age_q[i] != 12'hFFF) age_q[i] <= age_q[i] + 12'h001;
    end
  end
  assign rfc_ck = rfc_mode == 2'h0 ? 12'h058 :
                  rfc_mode == 2'h1 ? 12'h041 : 12'h028;
  assign wtr_ck = (crc_en && write_data_mask_en) ? 12'h008 : 12'h006;
  assign rd_i = dram_cmd_q inside {4'h4, 4'h5, 4'h9};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_lvl; dram_cmd_q == 4'hA; endsequence
  mod_wait_a: assert property (pda_mode && dram_cmd_q > 4'h1
    |-> age_q[0] >= 12'h018) else $error("command too soon after mode set");
  mrs_space_a: assert property (pda_mode && dram_cmd_q == 4'h1
    |-> age_q[0] >= 12'h010) else $error("mode sets too close");
  lvl_oe_a: assert property (s_lvl |-> ##[25:27] $rose(dqs_oe_q))
    else $error("strobe enable off time after leveling entry");
  lvl_edge_a: assert property (s_lvl |-> ##[40:42] $rose(dqs_edge_ok_q))
    else $error("first strobe edge off time after leveling entry");
  rfc_gap_a: assert property (dram_cmd_q inside {4'h2, 4'h3}
    |-> age_q[1] >= rfc_ck) else $error("refresh period cut short");
  dll_lock_a: assert property (rd_i |-> age_q[3] >= DLLK_CYC)
    else $error("dll command too soon after self refresh exit");
  wr_rd_a: assert property (rd_i |-> age_q[4] >= wtr_ck)
    else $error("read too soon after write");
  par_rsp_a: assert property (persist_par && $rose(par_err_q)
    |-> ##2 (dram_cmd_q == 4'h0) [*8]) else $error("no deselects after alert");
endmodule
bind dat_guard dat_guard_asserts #(.DLLK_CYC(DLLK_CYC)) u_asserts (
  .clk(clk), .nrst(nrst), .rfc_mode(rfc_mode), .pda_mode(pda_mode),
  .crc_en(crc_en), .write_data_mask_en(write_data_mask_en),
  .persist_par(persist_par), .dram_cmd_q(dram_cmd_q), .dqs_oe_q(dqs_oe_q),
  .dqs_edge_ok_q(dqs_edge_ok_q), .par_err_q(par_err_q));

// ---- dat_dev_model.sv ----
// model: device alert pin for parity and write crc errors
`timescale 1ns/1ps
module dat_dev_model
  import dat_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic grade_3200,
  input wire logic par_hit,
  input wire logic crc_hit,
  output logic     alert_n
);
  logic [7:0] wait_q;
  logic [7:0] len_q;
  logic [7:0] low_q;
  // one error at a time; an error inside a running pulse is not modelled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) {wait_q, len_q} <= 16'h0000;
    else if (par_hit) {wait_q, len_q} <= {8'(PL_NCK),
      grade_3200 ? 8'h60 : 8'h58};
    else if (crc_hit) {wait_q, len_q} <= 16'h0208;
    else if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) low_q <= 8'h00;
    else if (wait_q == 8'h01) low_q <= len_q;
    else if (low_q != 8'h00) low_q <= low_q - 8'h01;
  end
  assign alert_n = (low_q == 8'h00);
endmodule

// ---- dat_guard_tb.sv ----
// testbench: command timing guard against a device alert model
`timescale 1ns/1ps
module dat_guard_tb
  import dat_pkg::*;
;
  logic       clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_ready;
  logic       crc_en = 1'b0, msk_en = 1'b0, grade = 1'b0, par_hit = 1'b0;
  logic       crc_hit = 1'b0, alert_n, oe, edge_ok, par_err, lost, late;
  logic [3:0] req_cmd = 4'h0, cmd_q;
  logic [1:0] rfc_mode = 2'h0;
  int         n_errors = 0, checked = 0, w, n;
  // short dll lock keeps the run brief
  dat_guard #(.DLLK_CYC(8)) DUT (.clk(clk), .nrst(nrst), .req_cmd(req_cmd),
    .req_valid(req_valid), .req_ready(req_ready), .rfc_mode(rfc_mode),
    .pda_mode(1'b1), .crc_en(crc_en), .write_data_mask_en(msk_en),
    .persist_par(1'b1), .grade_3200(grade), .alert_n_pin(alert_n),
    .dram_cmd_q(cmd_q), .dqs_oe_q(oe), .dqs_edge_ok_q(edge_ok),
    .par_err_q(par_err), .cmd_lost_q(lost), .rsp_late_q(late));
  dat_dev_model dev (.clk(clk), .nrst(nrst), .grade_3200(grade),
    .par_hit(par_hit), .crc_hit(crc_hit), .alert_n(alert_n));
  function automatic int ck(int ns);
    return (ns * 1000 + 3999) / 4000;
  endfunction
  function automatic int rfc(logic [1:0] m);
    return m == 2'h0 ? ck(RFC1_NS) : m == 2'h1 ? ck(RFC2_NS) : ck(RFC4_NS);
  endfunction
  function automatic int wtr();
    return crc_en && msk_en ? ck(WR_CRC_DM_NS) + ck(WTR_CRC_DM_NS)
                            : ck(WR_NS) + ck(WTR_NS);
  endfunction
  task automatic chk(string s, logic [11:0] seen, logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", s, exp, seen);
    end
  endtask
  // holds the request until taken or refused 2000 cycles; k counts refused cycles
  task automatic send(input logic [3:0] c, output int k);
    req_cmd = c;
    req_valid = 1'b1;
    k = 0;
    #1;
    while (req_ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
      #1;
    end
    @(negedge clk);
    chk("issued command", 12'(cmd_q), 12'(c));
  endtask
  task automatic idle(input int k);
    req_valid = 1'b0;
    req_cmd = 4'h0;
    repeat (k) @(negedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always #2 clk = ~clk;
  initial begin
    #300000;
    n_errors++;
    results();
  end
  initial begin
    n = $urandom(84217);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    send(4'h1, w);
    send(4'h1, w);
    chk("mode set gap", 12'(w), 12'(ck(10) > 16 ? ck(10) : 16));
    send(4'h3, w);
    chk("mode update wait", 12'(w), 12'(MOD_NCK));
    $display("test mode_set done");
    idle(30);
    send(4'hA, w);
    idle(0);
    for (n = 0; n < 60 && oe !== 1'b1; n++) @(negedge clk);
    chk("strobe enable delay", 12'(n), 12'(WLDQSEN_NCK + 1));
    for (; n < 60 && edge_ok !== 1'b1; n++) @(negedge clk);
    chk("first edge delay", 12'(n), 12'(WLMRD_NCK + 1));
    send(4'h1, w);
    idle(100);
    $display("test leveling done");
    for (int i = 0; i < 30; i++) begin
      rfc_mode = 2'($urandom_range(2));
      crc_en = (i == 0) | 1'($urandom);
      msk_en = (i == 0) | 1'($urandom);
      send(4'h2, w);
      send($urandom_range(1) ? 4'h2 : 4'h3, w);
      chk("refresh gap", 12'(w), 12'(rfc(rfc_mode)));
      send(4'h6, w);
      send(i % 3 == 0 ? 4'h4 : i % 3 == 1 ? 4'h5 : 4'h9, w);
      chk("write to read", 12'(w), 12'(wtr()));
      idle(100);
    end
    $display("test refresh_write done");
    for (int k = 0; k < 3; k++) begin
      send(4'hB, w);
      send(k == 0 ? 4'h4 : k == 1 ? 4'h5 : 4'h9, w);
      chk("dll lock wait", 12'(w), 12'(8));
      idle(20);
    end
    $display("test self_refresh done");
    grade = 1'($urandom);
    send(4'h3, w);
    idle(0);
    par_hit = 1'b1;
    @(negedge clk);
    par_hit = 1'b0;
    for (n = 0; n < 40 && par_err !== 1'b1; n++) @(negedge clk);
    chk("lost flag", 12'(lost), 12'h001);
    chk("late flag", 12'(late), 12'h000);
    send(4'h3, w);
    chk("held during alert", 12'(w > 60), 12'h001);
    idle(5);
    crc_hit = 1'b1;
    @(negedge clk);
    crc_hit = 1'b0;
    // look once the whole short pulse has passed the length counter
    idle(20);
    chk("crc alert not parity", 12'(par_err), 12'h000);
    $display("test alerts done");
    results();
  end
endmodule
